// *** pdsr_dbg_host.sv ***
// Purpose: Model of the external debugger on the config-space scratch port
// Assumes: A request seen at one edge becomes a one-cycle write the next cycle
// Notes:   Write data toggles while idle so nothing can lean on a stale value
`timescale 1ns/100ps

module pdsr_dbg_host
(
  input  wire logic        clk_sys_in,        // Core clock
  input  wire logic        go_in,             // Request one scratch write
  input  wire logic [2:0]  idx_in,            // Scratch word index
  input  wire logic [31:0] data_in,           // Word to write
  output logic      [2:0]  cfg_scr_idx_out,   // Scratch index to bank
  output logic             cfg_scr_wr_out,    // Scratch write strobe
  output logic      [31:0] cfg_scr_wdata_out  // Scratch write data
);
  initial
  begin
    cfg_scr_idx_out   = 3'h0;
    cfg_scr_wr_out    = 1'b0;
    cfg_scr_wdata_out = 32'h0;
  end

  // Same storage as the status-port scratch words
  always @(posedge clk_sys_in)
  begin
    cfg_scr_wr_out <= go_in;
    if (go_in)
    begin
      cfg_scr_idx_out   <= idx_in;
      cfg_scr_wdata_out <= data_in;
    end
    else
      cfg_scr_wdata_out <= ~cfg_scr_wdata_out;
  end
endmodule

// *** pdsr_pkg.sv ***
// Purpose: Shared constants for the processor debug status register bank
// Assumes: Register numbers are word indices on the processor-status port
// Notes:   Field positions and cause codes used by the bank and its users
package pdsr_pkg;

  localparam logic [7:0]  PDSR_IDX_TCELL_OSC   = 8'h07;
  localparam logic [7:0]  PDSR_IDX_TWIRE_OSC   = 8'h08;
  localparam logic [7:0]  PDSR_IDX_PCELL_OSC   = 8'h09;
  localparam logic [7:0]  PDSR_IDX_PWIRE_OSC   = 8'h0A;
  localparam logic [7:0]  PDSR_IDX_RAM_SIZE    = 8'h0C;
  localparam logic [7:0]  PDSR_IDX_STATUS_COPY = 8'h10;
  localparam logic [7:0]  PDSR_IDX_PC_COPY     = 8'h11;
  localparam logic [7:0]  PDSR_IDX_SP_COPY     = 8'h12;
  localparam logic [7:0]  PDSR_IDX_RD_THREAD   = 8'h13;
  localparam logic [7:0]  PDSR_IDX_RD_REG      = 8'h14;
  localparam logic [7:0]  PDSR_IDX_IRQ_CAUSE   = 8'h15;
  localparam logic [7:0]  PDSR_IDX_IRQ_DETAIL  = 8'h16;
  localparam logic [7:0]  PDSR_IDX_STOP_MASK   = 8'h18;
  localparam logic [7:0]  PDSR_IDX_SCRATCH_LO  = 8'h20;
  localparam logic [7:0]  PDSR_IDX_SCRATCH_HI  = 8'h27;

  localparam int          PDSR_OSC_W           = 16;
  localparam int          PDSR_RAM_LSB         = 2;
  localparam int          PDSR_STAT_W          = 11;
  localparam logic [10:0] PDSR_STAT_DBG_MASK   = 11'h6DF;
  localparam logic [10:0] PDSR_STAT_RD_MASK    = 11'h7DF;
  localparam int          PDSR_THREAD_SEL_W    = 8;
  localparam int          PDSR_REG_SEL_W       = 5;
  localparam int          PDSR_CAUSE_LSB       = 0;
  localparam int          PDSR_CAUSE_W         = 3;
  localparam int          PDSR_THREAD_LSB      = 8;
  localparam int          PDSR_THREAD_W        = 8;
  localparam int          PDSR_UNIT_LSB        = 16;
  localparam int          PDSR_UNIT_W          = 2;
  localparam int          PDSR_NUM_UNITS       = 4;
  localparam int          PDSR_STOP_W          = 8;
  localparam int          PDSR_SCRATCH_N       = 8;

  localparam logic [2:0]  PDSR_CAUSE_NONE      = 3'h0;
  localparam logic [2:0]  PDSR_CAUSE_HOST      = 3'h1;
  localparam logic [2:0]  PDSR_CAUSE_DEBUG_CALL_INSTRUCTION     = 3'h2;
  localparam logic [2:0]  PDSR_CAUSE_IBREAK    = 3'h3;
  localparam logic [2:0]  PDSR_CAUSE_DWATCH    = 3'h4;
  localparam logic [2:0]  PDSR_CAUSE_RWATCH    = 3'h5;

endpackage

// *** pdsr_regs.sv ***
// Purpose: Processor status and debug state register bank of one tile
// Assumes: Single core clock; status port reads are combinational, writes take one edge
// Notes:   Oscillator counters run on oscillator-derived tick inputs, not on reset
// Functional notes
// - Four read-only oscillator counts, 16 bits low, upper bits zero.
// - Oscillator counters are not cleared by system reset.
// - RAM size in bytes readable, bits 31:2 value, low two bits zero.
// - Debugger entry captures the saved status word into its copy.
// - Status bits 0..4: events, interrupts, enabling sequence, handler, kernel.
// - Status bits 6..10: paused, fast, issue mode, kernel issue mode, space id.
// - Debugger entry captures the full saved program counter.
// - Debugger entry captures the full saved stack pointer.
// - Eight-bit thread select operand for the debug register read.
// - Five-bit register number operand for the debug register read.
// - Three-bit debug cause field, reset zero, codes one to five.
// - Two-bit trigger unit number, zero for host or call, lowest wins.
// - Eight-bit causing thread number, zero when the host requested.
// - Detail holds address on data watch, resource id on resource watch.
// - Eight-bit stop mask holds marked threads outside debug mode.
// - Eight scratch words shared with the tile configuration space.
`timescale 1ns/100ps

module pdsr_regs
  import pdsr_pkg::*;
#(
  parameter logic [31:0] RAM_BYTES = 32'h0008_0000
)
(
  input  wire logic        clk_sys_in,         // Tile core clock
  input  wire logic        rst_in,             // System reset, async high
  input  wire logic [3:0]  osc_tick_in,        // One-cycle ticks per oscillator
  input  wire logic        debug_mode_in,      // Processor in debug mode
  input  wire logic        dbg_enter_in,       // Pulse on debugger entry
  input  wire logic [10:0] saved_status_word_in,    // Live saved status word
  input  wire logic [31:0] saved_program_counter_in, // Live saved PC
  input  wire logic [31:0] saved_stack_pointer_in,   // Live saved SP
  input  wire logic [2:0]  enter_cause_in,     // Cause code of this entry
  input  wire logic [7:0]  enter_thread_in,    // Causing thread
  input  wire logic [3:0]  enter_units_in,     // Triggered units, one bit per unit, several may be set
  input  wire logic [31:0] enter_addr_in,      // Effective address of access
  input  wire logic [31:0] enter_res_id_in,    // Resource identifier
  input  wire logic [7:0]  ps_addr_in,         // Status register number
  input  wire logic        ps_wr_in,           // Status write strobe
  input  wire logic [31:0] ps_wdata_in,        // Status write data
  output logic      [31:0] ps_rdata_out,       // Status read data
  input  wire logic [2:0]  cfg_scr_idx_in,     // Config-space scratch index
  input  wire logic        cfg_scr_wr_in,      // Config-space scratch write
  input  wire logic [31:0] cfg_scr_wdata_in,   // Config-space scratch data
  output logic      [31:0] cfg_scr_rdata_out,  // Config-space scratch read
  output logic      [7:0]  thread_hold_out,    // Threads held from running
  output logic      [7:0]  rd_thread_sel_out,  // Register read thread operand
  output logic      [4:0]  rd_reg_sel_out      // Register read number operand
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] lowest_unit(input logic [3:0] units);
    logic [1:0] n;
    n = 2'h0;
    for (int i = PDSR_NUM_UNITS - 1; i >= 0; i--)
    begin
      if (units[i])
      begin
        n = 2'(i);
      end
    end
    return n;
  endfunction

  function automatic logic is_scratch(input logic [7:0] addr);
    return addr >= PDSR_IDX_SCRATCH_LO && addr <= PDSR_IDX_SCRATCH_HI;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator counters: power-up zero, no reset so counts survive a system reset
  logic [PDSR_OSC_W-1:0] osc_cnt_reg [4] = '{default: '0};
  logic [PDSR_OSC_W-1:0] osc_cnt_next [4];

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      osc_cnt_next[i] = osc_cnt_reg[i] + (osc_tick_in[i] ? 16'h0001 : 16'h0000);
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    osc_cnt_reg <= osc_cnt_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [PDSR_STAT_W-1:0]       status_reg, status_next;
  logic [31:0]                  pc_reg, pc_next;
  logic [31:0]                  sp_reg, sp_next;
  logic [PDSR_THREAD_SEL_W-1:0] rdt_reg, rdt_next;
  logic [PDSR_REG_SEL_W-1:0]    rdr_reg, rdr_next;
  logic [PDSR_CAUSE_W-1:0]      cause_reg, cause_next;
  logic [PDSR_THREAD_W-1:0]     cthr_reg, cthr_next;
  logic [PDSR_UNIT_W-1:0]       unit_reg, unit_next;
  logic [31:0]                  detail_reg, detail_next;
  logic [PDSR_STOP_W-1:0]       stop_reg, stop_next;
  logic [31:0]                  scr_reg [PDSR_SCRATCH_N];
  logic [31:0]                  scr_next [PDSR_SCRATCH_N];
  logic                         dwr;

  assign dwr = ps_wr_in && debug_mode_in;

  always_comb
  begin
    status_next = status_reg;
    pc_next     = pc_reg;
    sp_next     = sp_reg;
    rdt_next    = rdt_reg;
    rdr_next    = rdr_reg;
    cause_next  = cause_reg;
    cthr_next   = cthr_reg;
    unit_next   = unit_reg;
    detail_next = detail_reg;
    stop_next   = stop_reg;
    scr_next    = scr_reg;
    if (dwr)
    begin
      case (ps_addr_in)
        PDSR_IDX_STATUS_COPY:
        begin
          // Bit 8 stays read-only; bit 5 reserved
          status_next = (status_reg & ~PDSR_STAT_DBG_MASK)
                      | (ps_wdata_in[PDSR_STAT_W-1:0] & PDSR_STAT_DBG_MASK);
        end
        PDSR_IDX_PC_COPY:    pc_next  = ps_wdata_in;
        PDSR_IDX_SP_COPY:    sp_next  = ps_wdata_in;
        PDSR_IDX_RD_THREAD:  rdt_next = ps_wdata_in[PDSR_THREAD_SEL_W-1:0];
        PDSR_IDX_RD_REG:     rdr_next = ps_wdata_in[PDSR_REG_SEL_W-1:0];
        PDSR_IDX_IRQ_CAUSE:
        begin
          cause_next = ps_wdata_in[PDSR_CAUSE_LSB +: PDSR_CAUSE_W];
          cthr_next  = ps_wdata_in[PDSR_THREAD_LSB +: PDSR_THREAD_W];
          unit_next  = ps_wdata_in[PDSR_UNIT_LSB +: PDSR_UNIT_W];
        end
        PDSR_IDX_IRQ_DETAIL: detail_next = ps_wdata_in;
        PDSR_IDX_STOP_MASK:  stop_next   = ps_wdata_in[PDSR_STOP_W-1:0];
        default:
        begin
          if (is_scratch(ps_addr_in))
          begin
            scr_next[ps_addr_in[2:0]] = ps_wdata_in;
          end
        end
      endcase
    end
    // Config-space port written after the status port: same word, last wins
    if (cfg_scr_wr_in)
    begin
      scr_next[cfg_scr_idx_in] = cfg_scr_wdata_in;
    end
    // Hardware capture outranks a software write in the same cycle
    if (dbg_enter_in)
    begin
      status_next = saved_status_word_in;
      pc_next     = saved_program_counter_in;
      sp_next     = saved_stack_pointer_in;
      cause_next  = enter_cause_in;
      cthr_next   = (enter_cause_in == PDSR_CAUSE_HOST) ? 8'h00 : enter_thread_in;
      unit_next   = (enter_cause_in == PDSR_CAUSE_HOST || enter_cause_in == PDSR_CAUSE_DEBUG_CALL_INSTRUCTION)
                  ? 2'h0 : lowest_unit(enter_units_in);
      if (enter_cause_in == PDSR_CAUSE_DWATCH)
      begin
        detail_next = enter_addr_in;
      end
      else if (enter_cause_in == PDSR_CAUSE_RWATCH)
      begin
        detail_next = enter_res_id_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      status_reg <= '0;
      pc_reg     <= '0;
      sp_reg     <= '0;
      rdt_reg    <= '0;
      rdr_reg    <= '0;
      cause_reg  <= PDSR_CAUSE_NONE;
      cthr_reg   <= '0;
      unit_reg   <= '0;
      detail_reg <= '0;
      stop_reg   <= '0;
      scr_reg    <= '{default: 32'h0000_0000};
    end
    else
    begin
      status_reg <= status_next;
      pc_reg     <= pc_next;
      sp_reg     <= sp_next;
      rdt_reg    <= rdt_next;
      rdr_reg    <= rdr_next;
      cause_reg  <= cause_next;
      cthr_reg   <= cthr_next;
      unit_reg   <= unit_next;
      detail_reg <= detail_next;
      stop_reg   <= stop_next;
      scr_reg    <= scr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side: reserved bits and unmapped numbers read zero
  always_comb
  begin
    ps_rdata_out = 32'h0000_0000;
    case (ps_addr_in)
      PDSR_IDX_TCELL_OSC:   ps_rdata_out[PDSR_OSC_W-1:0] = osc_cnt_reg[0];
      PDSR_IDX_TWIRE_OSC:   ps_rdata_out[PDSR_OSC_W-1:0] = osc_cnt_reg[1];
      PDSR_IDX_PCELL_OSC:   ps_rdata_out[PDSR_OSC_W-1:0] = osc_cnt_reg[2];
      PDSR_IDX_PWIRE_OSC:   ps_rdata_out[PDSR_OSC_W-1:0] = osc_cnt_reg[3];
      PDSR_IDX_RAM_SIZE:
      begin
        ps_rdata_out[31:PDSR_RAM_LSB] = RAM_BYTES[31:PDSR_RAM_LSB];
      end
      PDSR_IDX_STATUS_COPY: ps_rdata_out[PDSR_STAT_W-1:0] = status_reg & PDSR_STAT_RD_MASK;
      PDSR_IDX_PC_COPY:     ps_rdata_out = pc_reg;
      PDSR_IDX_SP_COPY:     ps_rdata_out = sp_reg;
      PDSR_IDX_RD_THREAD:   ps_rdata_out[PDSR_THREAD_SEL_W-1:0] = rdt_reg;
      PDSR_IDX_RD_REG:      ps_rdata_out[PDSR_REG_SEL_W-1:0] = rdr_reg;
      PDSR_IDX_IRQ_CAUSE:
      begin
        ps_rdata_out[PDSR_CAUSE_LSB +: PDSR_CAUSE_W]   = cause_reg;
        ps_rdata_out[PDSR_THREAD_LSB +: PDSR_THREAD_W] = cthr_reg;
        ps_rdata_out[PDSR_UNIT_LSB +: PDSR_UNIT_W]     = unit_reg;
      end
      PDSR_IDX_IRQ_DETAIL:  ps_rdata_out = detail_reg;
      PDSR_IDX_STOP_MASK:   ps_rdata_out[PDSR_STOP_W-1:0] = stop_reg;
      default:
      begin
        if (is_scratch(ps_addr_in))
        begin
          ps_rdata_out = scr_reg[ps_addr_in[2:0]];
        end
      end
    endcase
  end

  assign cfg_scr_rdata_out = scr_reg[cfg_scr_idx_in];
  // Threads are held only while the processor runs outside debug mode
  assign thread_hold_out   = debug_mode_in ? 8'h00 : stop_reg;
  assign rd_thread_sel_out = rdt_reg;
  assign rd_reg_sel_out    = rdr_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_entry_pc_capture: assert property (dbg_enter_in |=> pc_reg == $past(saved_program_counter_in))
    else $error("PC copy not captured on entry");
  a_entry_sp_capture: assert property (dbg_enter_in |=> sp_reg == $past(saved_stack_pointer_in))
    else $error("SP copy not captured on entry");
  a_entry_status_cap: assert property (dbg_enter_in |=> status_reg == $past(saved_status_word_in))
    else $error("Status copy not captured on entry");
  a_host_thread_zero: assert property (dbg_enter_in && enter_cause_in == PDSR_CAUSE_HOST
      |=> cthr_reg == 8'h00 && unit_reg == 2'h0)
    else $error("Host entry left nonzero thread or unit");
  a_lowest_unit_wins: assert property (dbg_enter_in && enter_units_in[0]
      && enter_cause_in == PDSR_CAUSE_IBREAK |=> unit_reg == 2'h0)
    else $error("Lowest triggered unit not recorded");
  a_dwatch_detail: assert property (dbg_enter_in && enter_cause_in == PDSR_CAUSE_DWATCH
      |=> detail_reg == $past(enter_addr_in))
    else $error("Data watch address not recorded");
  a_no_write_outside: assert property (!debug_mode_in && !dbg_enter_in
      |=> $stable(stop_reg) && $stable(rdt_reg))
    else $error("Debug field changed outside debug mode");
  a_stop_hold_run: assert property (!debug_mode_in |-> thread_hold_out == stop_reg)
    else $error("Stop mask not applied outside debug mode");
  a_reserved_zero: assert property (ps_addr_in == PDSR_IDX_TCELL_OSC
      |-> ps_rdata_out[31:PDSR_OSC_W] == 16'h0000)
    else $error("Oscillator reserved bits not zero");
  a_ram_low_zero: assert property (ps_addr_in == PDSR_IDX_RAM_SIZE
      |-> ps_rdata_out[1:0] == 2'h0 && ps_rdata_out[31:2] == RAM_BYTES[31:2])
    else $error("RAM size read wrong");

  // Entry capture of cause, thread, unit and detail
  a_entry_cause_cap: assert property (dbg_enter_in
      |=> cause_reg == $past(enter_cause_in))
    else $error("Cause code not captured on entry");
  a_call_unit_zero: assert property (dbg_enter_in && enter_cause_in == PDSR_CAUSE_DEBUG_CALL_INSTRUCTION
      |=> unit_reg == 2'h0)
    else $error("Call entry left nonzero unit");
  a_thread_captured: assert property (dbg_enter_in && enter_cause_in != PDSR_CAUSE_HOST
      |=> cthr_reg == $past(enter_thread_in))
    else $error("Causing thread not recorded");
  a_rwatch_detail: assert property (dbg_enter_in && enter_cause_in == PDSR_CAUSE_RWATCH
      |=> detail_reg == $past(enter_res_id_in))
    else $error("Resource id not recorded");
  a_detail_kept: assert property (dbg_enter_in && enter_cause_in != PDSR_CAUSE_DWATCH
      && enter_cause_in != PDSR_CAUSE_RWATCH && !(dwr && ps_addr_in == PDSR_IDX_IRQ_DETAIL)
      |=> $stable(detail_reg))
    else $error("Detail changed on a non-watch entry");

  // Software-written fields
  a_stop_write_lands: assert property (dwr && ps_addr_in == PDSR_IDX_STOP_MASK
      |=> stop_reg == $past(ps_wdata_in[PDSR_STOP_W-1:0]))
    else $error("Stop mask write lost");
  a_hold_in_debug: assert property (debug_mode_in |-> thread_hold_out == 8'h00)
    else $error("Threads held in debug mode");
  a_thread_sel_write: assert property (dwr && ps_addr_in == PDSR_IDX_RD_THREAD
      |=> rd_thread_sel_out == $past(ps_wdata_in[PDSR_THREAD_SEL_W-1:0]))
    else $error("Thread select write lost");
  a_reg_sel_write: assert property (dwr && ps_addr_in == PDSR_IDX_RD_REG
      |=> rd_reg_sel_out == $past(ps_wdata_in[PDSR_REG_SEL_W-1:0]))
    else $error("Register select write lost");
  a_status_fixed: assert property (!dbg_enter_in
      |=> $stable(status_reg & ~PDSR_STAT_DBG_MASK))
    else $error("Read-only status bit changed without entry");
  a_status_rsvd_zero: assert property (ps_addr_in == PDSR_IDX_STATUS_COPY
      |-> ps_rdata_out[31:PDSR_STAT_W] == '0
      && (ps_rdata_out[PDSR_STAT_W-1:0] & ~PDSR_STAT_RD_MASK) == '0)
    else $error("Status reserved bits not zero");
  a_scratch_cfg_write: assert property (cfg_scr_wr_in
      |=> scr_reg[$past(cfg_scr_idx_in)] == $past(cfg_scr_wdata_in))
    else $error("Config scratch write lost");
  a_scratch_ps_write: assert property (dwr && is_scratch(ps_addr_in) && !cfg_scr_wr_in
      |=> scr_reg[$past(ps_addr_in[2:0])] == $past(ps_wdata_in))
    else $error("Status-port scratch write lost");

  // Oscillator counts; the reset check must not be masked by the reset itself
  a_osc_upper_zero: assert property (ps_addr_in >= PDSR_IDX_TCELL_OSC
      && ps_addr_in <= PDSR_IDX_PWIRE_OSC |-> ps_rdata_out[31:PDSR_OSC_W] == '0)
    else $error("Oscillator upper bits not zero");
  a_osc_count_step: assert property (osc_tick_in[0]
      |=> osc_cnt_reg[0] == $past(osc_cnt_reg[0]) + 16'h0001)
    else $error("Oscillator count did not advance");
  a_osc_keep_reset: assert property (disable iff (1'b0) rst_in && !osc_tick_in[0]
      ##1 rst_in |-> $stable(osc_cnt_reg[0]))
    else $error("Oscillator count disturbed by reset");

  c_host_entry:  cover property (dbg_enter_in && enter_cause_in == PDSR_CAUSE_HOST);
  c_data_watch:  cover property (dbg_enter_in && enter_cause_in == PDSR_CAUSE_DWATCH);
  c_res_watch:   cover property (dbg_enter_in && enter_cause_in == PDSR_CAUSE_RWATCH);
  c_stop_write:  cover property (dwr && ps_addr_in == PDSR_IDX_STOP_MASK);
  c_cfg_scratch: cover property (cfg_scr_wr_in ##1 ps_addr_in == PDSR_IDX_SCRATCH_LO);

endmodule

// *** tb.sv ***
// Purpose: Self-checking bench for the debug status register bank
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes:   Oscillator counts start at zero and are never reset
`timescale 1ns/100ps

module tb;
  import pdsr_pkg::*;
  localparam logic [31:0] RAM = 32'h0004_0000;
  logic        clk_sys_in = 1'b0, rst_in = 1'b1, debug_mode_in = 1'b1;
  logic        dbg_enter_in = 1'b0, ps_wr_in = 1'b0, go = 1'b0;
  logic [3:0]  osc_tick_in = 4'h0, enter_units_in = 4'h6;
  logic [10:0] saved_status_word_in = 11'h7FF;
  logic [31:0] saved_program_counter_in = 32'h8000_1234;
  logic [31:0] saved_stack_pointer_in = 32'h0001_FFF0;
  logic [31:0] enter_addr_in = 32'h0002_0040, enter_res_id_in = 32'h0000_0A02;
  logic [31:0] ps_wdata_in = 32'h0, det, exp_irq;
  logic [2:0]  enter_cause_in = 3'h0, cfg_scr_idx_in;
  logic [7:0]  enter_thread_in = 8'h3C, ps_addr_in = 8'h00;
  logic [31:0] ps_rdata_out, cfg_scr_rdata_out, cfg_scr_wdata_in;
  logic        cfg_scr_wr_in;
  logic [7:0]  thread_hold_out, rd_thread_sel_out;
  logic [4:0]  rd_reg_sel_out;
  int          miscompares = 0, n_tests = 0, cyc = 0;

  // Rows: address, write data, value read back in debug mode
  localparam logic [7:0] R_A [0:10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
    8'h15, 8'h16, 8'h18, 8'h23, 8'h30, 8'h0C};
  localparam logic [31:0] R_D [0:10] = '{32'hFFFF_FFFF, 32'hA5A5_C3C3,
    32'h5A5A_3C3C, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h1234_5678,
    32'hFFFF_FFFF, 32'hCAFE_F00D, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  localparam logic [31:0] R_E [0:10] = '{32'h0000_06DF, 32'hA5A5_C3C3,
    32'h5A5A_3C3C, 32'h0000_00FF, 32'h0000_001F, 32'h0003_FF07, 32'h1234_5678,
    32'h0000_00FF, 32'hCAFE_F00D, 32'h0000_0000, {RAM[31:2], 2'h0}};

  pdsr_regs #(.RAM_BYTES(RAM)) i_dut (.clk_sys_in, .rst_in, .osc_tick_in,
    .debug_mode_in, .dbg_enter_in, .saved_status_word_in,
    .saved_program_counter_in, .saved_stack_pointer_in, .enter_cause_in,
    .enter_thread_in, .enter_units_in, .enter_addr_in, .enter_res_id_in,
    .ps_addr_in, .ps_wr_in, .ps_wdata_in, .ps_rdata_out, .cfg_scr_idx_in,
    .cfg_scr_wr_in, .cfg_scr_wdata_in, .cfg_scr_rdata_out, .thread_hold_out,
    .rd_thread_sel_out, .rd_reg_sel_out);

  pdsr_dbg_host i_host (.clk_sys_in, .go_in(go), .idx_in(3'h3),
    .data_in(32'h0BAD_BEEF), .cfg_scr_idx_out(cfg_scr_idx_in),
    .cfg_scr_wr_out(cfg_scr_wr_in), .cfg_scr_wdata_out(cfg_scr_wdata_in));

  always #5 clk_sys_in = ~clk_sys_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    ps_addr_in  <= a;
    ps_wdata_in <= d;
    ps_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    ps_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in);
    ps_addr_in <= a;
    #1 chk(ps_rdata_out, exp);
  endtask

  // A hang ends the run through the same report
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(8'h15, 32'h0);
    chk({24'h0, thread_hold_out}, 32'h0);
    for (int i = 0; i <= 10; i++)
    begin
      wr(R_A[i], R_D[i]);
      rd(R_A[i], R_E[i]);
    end
    chk({24'h0, rd_thread_sel_out}, 32'hFF);
    chk({27'h0, rd_reg_sel_out}, 32'h1F);
    // Twenty ticks on each oscillator; counts are final at once, then ten idle cycles
    osc_tick_in <= 4'hF;
    repeat (20) @(posedge clk_sys_in);
    osc_tick_in <= 4'h0;
    repeat (10) @(posedge clk_sys_in);
    for (int i = 7; i <= 10; i++)
    begin
      rd(i[7:0], 32'h0000_0014);
      chk(ps_rdata_out & 32'hFFFF_0000, 32'h0);
    end
    @(posedge clk_sys_in);
    debug_mode_in <= 1'b0;
    #1 chk({24'h0, thread_hold_out}, 32'hFF);
    wr(8'h18, 32'h0);
    rd(8'h18, 32'hFF);
    @(posedge clk_sys_in);
    debug_mode_in <= 1'b1;
    #1 chk({24'h0, thread_hold_out}, 32'h0);
    det = 32'h1234_5678;
    for (int c = 1; c <= 5; c++)
    begin
      @(posedge clk_sys_in);
      dbg_enter_in   <= 1'b1;
      enter_cause_in <= c[2:0];
      @(posedge clk_sys_in);
      dbg_enter_in   <= 1'b0;
      if (c == 4)
        det = enter_addr_in;
      if (c == 5)
        det = enter_res_id_in;
      exp_irq = {14'h0, (c > 2) ? 2'h1 : 2'h0, (c == 1) ? 8'h0 : 8'h3C, 5'h0, c[2:0]};
      rd(8'h15, exp_irq);
      rd(8'h16, det);
    end
    // Several units at once: the lowest one is recorded
    @(posedge clk_sys_in);
    enter_units_in <= 4'h9;
    dbg_enter_in   <= 1'b1;
    enter_cause_in <= PDSR_CAUSE_IBREAK;
    @(posedge clk_sys_in);
    dbg_enter_in   <= 1'b0;
    rd(8'h15, 32'h0000_3C03);
    rd(8'h10, 32'h0000_07DF);
    rd(8'h11, saved_program_counter_in);
    rd(8'h12, saved_stack_pointer_in);
    // Second reset: debug state clears, oscillator counts stay
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(8'h15, 32'h0);
    rd(8'h18, 32'h0);
    for (int i = 7; i <= 10; i++)
    begin
      rd(i[7:0], 32'h0000_0014);
    end
    @(posedge clk_sys_in);
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
    rd(8'h23, 32'h0BAD_BEEF);
    chk(cfg_scr_rdata_out, 32'h0BAD_BEEF);
    print_verdict();
  end
endmodule
